// >>> logic/crso_pkg.sv
// Shared constants for the completer request output stream.
// Assumes a single core clock; all widths are in bits unless named dwords.
package crso_pkg;
    // Widest payload bus and its dword keep mask
    localparam int MAX_BUS_W = 256;
    localparam int MAX_KEEP_W = 8;
    // Allowed payload bus widths
    localparam int BUS_W_64 = 64;
    localparam int BUS_W_128 = 128;
    localparam int BUS_W_256 = 256;
    // Dwords and bytes
    localparam int DWORD_W = 32;
    localparam int BYTES_PER_DWORD = 4;
    // Request descriptor length ahead of the payload, in dwords
    localparam int DESC_DWORDS = 4;
    // Largest payload of one request, in dwords
    localparam int MAX_PAYLOAD_DWORDS = 1024;
    localparam int LEN_W = 11;
    localparam int DW_CNT_W = 12;
    // Sideband bundle layout
    localparam int SIDEBAND_W = 85;
    localparam int SB_FIRST_MASK_LSB = 0;
    localparam int SB_FINAL_MASK_LSB = 4;
    localparam int SB_BYTE_EN_LSB = 8;
    localparam int SB_BYTE_EN_W = 32;
    localparam int SB_SOP_BIT = 40;
    localparam int SB_EXTRA_LSB = 41;
    localparam int SB_EXTRA_W = 44;
    // Byte mask forced for atomics and messages with payload
    localparam logic [3:0] MASK_ALL_BYTES = 4'hf;
    // Default depth of the packet store, in beats
    localparam int STORE_DEPTH = 1024;
endpackage : crso_pkg

// >>> logic/crso_store.sv
// Beat store for whole request packets: one write port, one read port.
// Assumes the caller never writes a full store; read data come from a register.
`timescale 1ns/1ps
`default_nettype none
module crso_store #(
    parameter int WIDTH = 350,
    parameter int DEPTH = 1024,
    parameter int ADDR_W = 10
) (
    // Clock
    input wire logic ref_clk_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // Read port, data register only updates on a read
    input wire logic rd_en_i,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);
    // Storage array, no reset needed
    logic [WIDTH-1:0] mem [DEPTH];

    // Write and registered read
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i)
        begin
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule // crso_store
`default_nettype wire

// >>> logic/crso_top.sv
// Completer request output stream: frames each received request into beats.
// Assumes the link side presents requests as packed beats on the same clock,
// descriptor first, with the request fields held on the first beat.
//
// Contract
// [RULE1] Every received request leaves as one packet
// [RULE2] Payload bus width is 64, 128 or 256
// [RULE3] Unused upper payload bits are tied zero
// [RULE4] 85-bit sideband, meaningful only while valid
// [RULE5] Last marker only on final beat
// [RULE6] Single-beat request raises last immediately
// [RULE7] One keep bit per payload dword
// [RULE8] Keep contiguous, full except partial final beat
// [RULE9] Unused upper keep bits are tied zero
// [RULE10] Valid high exactly when content is presented
// [RULE11] Valid stays high throughout a started packet
// [RULE12] User raises accept, may drop it anytime
// [RULE13] Beat moves only when valid and accept
// [RULE14] Stalled beat holds every output unchanged
// [RULE15] Start flag marks each packet's first beat
// [RULE16] Byte masks copied, forced ones when required
// [RULE17] Byte enables clear for descriptor, zero-length
// [RULE18] Reset holds valid and last low
`timescale 1ns/1ps
`default_nettype none
module crso_top #(
    parameter int BUS_W = crso_pkg::BUS_W_256,
    parameter int DEPTH = crso_pkg::STORE_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Received requests from the link side
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    input wire logic [BUS_W-1:0] rx_data_i,
    input wire logic [crso_pkg::LEN_W-1:0] rx_payload_dwords_i,
    input wire logic rx_zero_length_i,
    input wire logic rx_force_full_masks_i,
    input wire logic [3:0] rx_first_dword_byte_mask_i,
    input wire logic [3:0] rx_final_dword_byte_mask_i,
    input wire logic [crso_pkg::SB_EXTRA_W-1:0] rx_extra_sideband_i,
    // Output stream to the user application
    output logic [crso_pkg::MAX_BUS_W-1:0] request_out_payload,
    output logic [crso_pkg::MAX_KEEP_W-1:0] request_out_dword_keep,
    output logic [crso_pkg::SIDEBAND_W-1:0] request_out_sideband,
    output logic request_out_last_beat,
    output logic request_out_valid,
    input wire logic request_out_accept
);
    // Derived sizes
    localparam int NDW = BUS_W / crso_pkg::DWORD_W;
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int WORD_W = BUS_W + crso_pkg::MAX_KEEP_W + crso_pkg::SIDEBAND_W + 1;
    localparam int MAX_BEATS =
        (crso_pkg::DESC_DWORDS + crso_pkg::MAX_PAYLOAD_DWORDS + NDW - 1) / NDW;
    localparam logic [crso_pkg::DW_CNT_W-1:0] DESC_CNT = crso_pkg::DW_CNT_W'(crso_pkg::DESC_DWORDS);
    localparam logic [crso_pkg::DW_CNT_W-1:0] NDW_CNT = crso_pkg::DW_CNT_W'(NDW);

    // Refuse widths and depths the logic cannot serve
    if (BUS_W != crso_pkg::BUS_W_64 && BUS_W != crso_pkg::BUS_W_128 &&
        BUS_W != crso_pkg::BUS_W_256)
    begin : g_bad_width
        $error("Payload bus width must be 64, 128 or 256"); // see [RULE2]
    end
    if (DEPTH < MAX_BEATS || (1 << ADDR_W) != DEPTH)
    begin : g_bad_depth
        $error("Store depth must be a power of two holding the largest packet");
    end

    // All module state except the check helper exp_sop_r in one record
    typedef struct packed {
        logic rst_meta;                              // Reset release, first stage
        logic rst_n;                                 // Reset release, second stage
        logic rx_ready;                              // Room for one more beat
        logic in_pkt;                                // Between first and last write
        logic [crso_pkg::DW_CNT_W-1:0] base;         // Dword index of the next beat
        logic [crso_pkg::DW_CNT_W-1:0] tot;          // Dwords of the current packet
        logic zero;                                  // Zero-length write
        logic force1;                                // Masks forced to all ones
        logic [3:0] first_mask;                      // First payload dword mask
        logic [3:0] final_mask;                      // Final payload dword mask
        logic [crso_pkg::SB_EXTRA_W-1:0] extra;      // Remaining sideband fields
        logic [ADDR_W:0] wr_ptr;                     // Next write slot
        logic [ADDR_W:0] commit_ptr;                 // End of whole stored packets
        logic [ADDR_W:0] rd_ptr;                     // Next read slot
        logic a_v;                                   // Store read register holds a beat
        logic out_v;                                 // Output stage holds a beat
        logic out_last;                              // Output last marker
        logic [crso_pkg::MAX_KEEP_W-1:0] out_keep;   // Output keep mask
        logic [crso_pkg::SIDEBAND_W-1:0] out_side;   // Output sideband
        logic [BUS_W-1:0] out_data;                  // Output payload
    } crso_state_t;

    crso_state_t st_r;   // Registered state
    crso_state_t st_nxt; // Next state

    // Per-beat framing terms for the incoming beat
    logic [crso_pkg::DW_CNT_W-1:0] cur_tot;
    logic cur_zero;
    logic cur_force;
    logic [3:0] cur_first;
    logic [3:0] cur_final;
    logic [crso_pkg::MAX_KEEP_W-1:0] keep_w;
    logic [crso_pkg::SB_BYTE_EN_W-1:0] ben_w;
    logic last_w;
    logic [WORD_W-1:0] wr_word;
    logic [WORD_W-1:0] rd_word;
    logic wr_en;
    logic issue;
    logic move_ab;

    // Packet fields come live on the first beat, from storage afterwards
    always_comb
    begin
        if (st_r.in_pkt)
        begin
            cur_tot = st_r.tot;
            cur_zero = st_r.zero;
            cur_force = st_r.force1;
            cur_first = st_r.first_mask;
            cur_final = st_r.final_mask;
        end
        else
        begin
            // Zero-length write still carries one dword
            cur_tot = DESC_CNT + (rx_zero_length_i ? crso_pkg::DW_CNT_W'(1) :
                      crso_pkg::DW_CNT_W'(rx_payload_dwords_i));
            cur_zero = rx_zero_length_i;
            cur_force = rx_force_full_masks_i;
            cur_first = rx_first_dword_byte_mask_i;
            cur_final = rx_final_dword_byte_mask_i;
        end
    end

    // Keep and byte enables, one slice per dword lane
    for (genvar g = 0; g < crso_pkg::MAX_KEEP_W; g++)
    begin : g_lane
        logic [crso_pkg::DW_CNT_W-1:0] idx; // Dword index within the packet
        assign idx = st_r.base + crso_pkg::DW_CNT_W'(g);
        // Lanes above the bus width stay zero
        assign keep_w[g] = (g < NDW) && (idx < cur_tot); // see [RULE7] see [RULE8] see [RULE9]
        assign ben_w[g*4 +: 4] = (!keep_w[g] || idx < DESC_CNT || cur_zero) ? 4'h0 :
                                 cur_force ? crso_pkg::MASK_ALL_BYTES :
                                 (idx == DESC_CNT) ? cur_first :
                                 (idx == cur_tot - crso_pkg::DW_CNT_W'(1)) ? cur_final :
                                 crso_pkg::MASK_ALL_BYTES; // see [RULE17]
    end

    // Final beat once this beat reaches the packet's last dword
    assign last_w = (st_r.base + NDW_CNT) >= cur_tot; // see [RULE5] see [RULE6]
    assign wr_en = rx_valid_i && st_r.rx_ready;

    // Stored beat: last, sideband, keep, payload
    always_comb
    begin
        wr_word = {last_w,
                   (st_r.in_pkt ? st_r.extra : rx_extra_sideband_i),
                   !st_r.in_pkt, // see [RULE15]
                   ben_w,
                   (cur_force ? crso_pkg::MASK_ALL_BYTES : cur_final), // see [RULE16]
                   (cur_force ? crso_pkg::MASK_ALL_BYTES : cur_first), // see [RULE16]
                   keep_w,
                   rx_data_i};
    end

    // Read side: store register feeds the output stage without gaps
    assign move_ab = st_r.a_v && (!st_r.out_v || request_out_accept); // see [RULE13]
    assign issue = (st_r.rd_ptr != st_r.commit_ptr) && (!st_r.a_v || move_ab); // see [RULE1]

    // Packet store
    crso_store #(
        .WIDTH(WORD_W),
        .DEPTH(DEPTH),
        .ADDR_W(ADDR_W)
    ) u_store (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(wr_en),
        .wr_addr_i(st_r.wr_ptr[ADDR_W-1:0]),
        .wr_data_i(wr_word),
        .rd_en_i(issue),
        .rd_addr_i(st_r.rd_ptr[ADDR_W-1:0]),
        .rd_data_o(rd_word)
    );

    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rst_meta = 1'b1;
        st_nxt.rst_n = st_r.rst_meta;
        // Write one beat; commit only once the whole packet is stored
        if (wr_en)
        begin
            st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
            if (last_w)
            begin
                st_nxt.in_pkt = 1'b0;
                st_nxt.base = '0;
                st_nxt.commit_ptr = st_r.wr_ptr + 1'b1; // see [RULE11]
            end
            else
            begin
                st_nxt.in_pkt = 1'b1;
                st_nxt.base = st_r.base + NDW_CNT;
                st_nxt.tot = cur_tot;
                st_nxt.zero = cur_zero;
                st_nxt.force1 = cur_force;
                st_nxt.first_mask = cur_first;
                st_nxt.final_mask = cur_final;
                st_nxt.extra = st_r.in_pkt ? st_r.extra : rx_extra_sideband_i;
            end
        end
        // Read one beat into the store register
        if (issue)
        begin
            st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
        end
        st_nxt.a_v = issue || (st_r.a_v && !move_ab);
        // Output stage loads, drains, or holds while stalled
        if (move_ab)
        begin
            st_nxt.out_v = 1'b1; // see [RULE10]
            st_nxt.out_data = rd_word[BUS_W-1:0];
            st_nxt.out_keep = rd_word[BUS_W +: crso_pkg::MAX_KEEP_W];
            st_nxt.out_side = rd_word[BUS_W + crso_pkg::MAX_KEEP_W +: crso_pkg::SIDEBAND_W];
            st_nxt.out_last = rd_word[WORD_W-1];
        end
        else if (request_out_accept)
        begin
            st_nxt.out_v = 1'b0;
            st_nxt.out_last = 1'b0;
        end
        // Otherwise everything holds: see [RULE14]
        // Room for one more beat after this cycle's moves
        st_nxt.rx_ready = st_r.rst_n &&
                          ((st_nxt.wr_ptr - st_nxt.rd_ptr) < (ADDR_W+1)'(DEPTH));
    end

    // State register; the reset release stages share the asynchronous reset
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_r <= '0; // see [RULE18]
        end
        else if (!st_r.rst_n)
        begin
            // Held quiet until the released reset reaches the second stage
            st_r <= '0;
            st_r.rst_meta <= 1'b1;
            st_r.rst_n <= st_r.rst_meta;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign rx_ready_o = st_r.rx_ready;
    assign request_out_payload = crso_pkg::MAX_BUS_W'(st_r.out_data); // see [RULE3]
    assign request_out_dword_keep = st_r.out_keep;
    assign request_out_sideband = st_r.out_side; // see [RULE4]
    assign request_out_last_beat = st_r.out_last;
    assign request_out_valid = st_r.out_v;

    // Helper: next presented beat is expected to open a packet
    logic exp_sop_r;
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            exp_sop_r <= 1'b1;
        end
        else if (st_r.out_v && request_out_accept)
        begin
            exp_sop_r <= st_r.out_last;
        end
    end

    a_hold_stall: assert property (@(posedge ref_clk_i) disable iff (!st_r.rst_n) // see [RULE14]
        request_out_valid && !request_out_accept |=> request_out_valid &&
        $stable(request_out_payload) && $stable(request_out_dword_keep) &&
        $stable(request_out_sideband) && $stable(request_out_last_beat))
        else $error("Stalled beat changed");
    a_no_gap: assert property (@(posedge ref_clk_i) disable iff (!st_r.rst_n) // see [RULE11]
        request_out_valid && request_out_accept && !request_out_last_beat |=> request_out_valid)
        else $error("Gap inside packet");
    a_sop_first: assert property (@(posedge ref_clk_i) disable iff (!st_r.rst_n) // see [RULE15]
        request_out_valid |-> request_out_sideband[crso_pkg::SB_SOP_BIT] == exp_sop_r)
        else $error("Start flag wrong");
    a_keep_full: assert property (@(posedge ref_clk_i) disable iff (!st_r.rst_n) // see [RULE8]
        request_out_valid && !request_out_last_beat |->
        request_out_dword_keep == crso_pkg::MAX_KEEP_W'((1 << NDW) - 1))
        else $error("Keep not full before last beat");
    a_keep_low: assert property (@(posedge ref_clk_i) disable iff (!st_r.rst_n) // see [RULE8]
        request_out_valid |-> request_out_dword_keep[0])
        else $error("Keep lane zero clear");
    a_keep_upper: assert property (@(posedge ref_clk_i) disable iff (!st_r.rst_n) // see [RULE9]
        (request_out_dword_keep >> NDW) == '0)
        else $error("Keep upper lanes set");
    a_payload_upper: assert property (@(posedge ref_clk_i) disable iff (!st_r.rst_n) // see [RULE3]
        (request_out_payload >> BUS_W) == '0)
        else $error("Payload upper bits set");
    a_desc_ben: assert property (@(posedge ref_clk_i) disable iff (!st_r.rst_n) // see [RULE17]
        request_out_valid && request_out_sideband[crso_pkg::SB_SOP_BIT] |->
        request_out_sideband[crso_pkg::SB_BYTE_EN_LSB +: 16] == 16'h0000)
        else $error("Descriptor byte enables set");
endmodule // crso_top
`default_nettype wire

// >>> test/crso_sink.sv
// User-side sink model for the request output stream.
// Assumes one core clock; mode 0 holds accept low, 1 accepts always, 2 alternates.
`timescale 1ns/1ps
`default_nettype none
module crso_sink (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Pacing mode from the bench
    input wire logic [1:0] mode_i,
    // Stream handshake
    input wire logic request_out_valid,
    output logic request_out_accept,
    // Beats counted as transferred
    output logic [15:0] beats_o
);
    // Accept is changed only just after a rising edge
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            request_out_accept <= 1'b0;
            beats_o <= 16'h0000;
        end
        else
        begin
            // Pause or pace the flow as asked
            request_out_accept <= (mode_i == 2'h1) || (mode_i == 2'h2 && !request_out_accept);
            // A beat moves only with valid and accept both high
            if (request_out_valid && request_out_accept)
            begin
                beats_o <= beats_o + 16'h0001;
            end
        end
    end
endmodule // crso_sink
`default_nettype wire

// >>> test/crso_top_test.sv
// Self-checking bench for the request output stream at a 64-bit bus width.
// Assumes the sink model paces accept; packets are stored whole before output.
`timescale 1ns/1ps
`default_nettype none
module crso_top_test;
    localparam int BW = 64;
    // Clock, reset and link side
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic rx_valid_i = 1'b0;
    logic rx_ready_o;
    logic [BW-1:0] rx_data_i = '0;
    logic [crso_pkg::LEN_W-1:0] rx_payload_dwords_i = '0;
    logic rx_zero_length_i = 1'b0;
    logic rx_force_full_masks_i = 1'b0;
    logic [3:0] rx_first_dword_byte_mask_i = 4'h0;
    logic [3:0] rx_final_dword_byte_mask_i = 4'h0;
    logic [crso_pkg::SB_EXTRA_W-1:0] rx_extra_sideband_i = '0;
    // Output stream
    logic [crso_pkg::MAX_BUS_W-1:0] request_out_payload;
    logic [crso_pkg::MAX_KEEP_W-1:0] request_out_dword_keep;
    logic [crso_pkg::SIDEBAND_W-1:0] request_out_sideband;
    logic request_out_last_beat;
    logic request_out_valid;
    logic request_out_accept;
    // Sink control and bookkeeping
    logic [1:0] sink_mode = 2'h0;
    logic [15:0] sink_beats;
    logic held = 1'b0;
    logic [351:0] snap = '0;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;

    always #2 ref_clk_i = ~ref_clk_i;

    crso_top #(.BUS_W(BW), .DEPTH(1024)) u_crso_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .rx_data_i(rx_data_i),
        .rx_payload_dwords_i(rx_payload_dwords_i), .rx_zero_length_i(rx_zero_length_i),
        .rx_force_full_masks_i(rx_force_full_masks_i),
        .rx_first_dword_byte_mask_i(rx_first_dword_byte_mask_i),
        .rx_final_dword_byte_mask_i(rx_final_dword_byte_mask_i),
        .rx_extra_sideband_i(rx_extra_sideband_i), .request_out_payload(request_out_payload),
        .request_out_dword_keep(request_out_dword_keep),
        .request_out_sideband(request_out_sideband),
        .request_out_last_beat(request_out_last_beat), .request_out_valid(request_out_valid),
        .request_out_accept(request_out_accept));

    crso_sink u_crso_sink (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .mode_i(sink_mode),
        .request_out_valid(request_out_valid), .request_out_accept(request_out_accept),
        .beats_o(sink_beats));

    // Compare and count
    task automatic chk(input string what, input logic [351:0] seen, input logic [351:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Counts and verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Dword d of packet pk, zero past the packet end
    function automatic logic [31:0] dw(input int pk, input int d, input int tot);
        return (d < tot) ? {8'hd0, 8'(pk), 16'(d)} : 32'h0000_0000;
    endfunction

    // Hang guard
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            close_out();
        end
    end

    // A stalled beat must not change at all
    always @(negedge ref_clk_i)
    begin
        if (held)
            chk("stalled outputs", 352'({request_out_payload, request_out_dword_keep,
                request_out_sideband, request_out_last_beat,
                request_out_valid}), snap);
        held = request_out_valid && !request_out_accept && nrst_i;
        snap = 352'({request_out_payload, request_out_dword_keep, request_out_sideband,
            request_out_last_beat, request_out_valid});
    end

    // Offer one packet beat by beat, holding each until taken
    task automatic send_pkt(input int pk, input int len, input logic zl, input logic ff,
        input logic [3:0] fm, input logic [3:0] lm);
        int tot;
        tot = 4 + len;
        @(posedge ref_clk_i);
        for (int b = 0; b < (tot + 1) / 2; b++)
        begin
            rx_valid_i <= 1'b1;
            rx_data_i <= {dw(pk, 2 * b + 1, tot), dw(pk, 2 * b, tot)};
            rx_payload_dwords_i <= 11'(len);
            rx_zero_length_i <= zl;
            rx_force_full_masks_i <= ff;
            rx_first_dword_byte_mask_i <= fm;
            rx_final_dword_byte_mask_i <= lm;
            rx_extra_sideband_i <= 44'h0ab_cd00_0000 + 44'(pk);
            @(posedge ref_clk_i);
            while (rx_ready_o !== 1'b1)
                @(posedge ref_clk_i);
        end
        rx_valid_i <= 1'b0;
    endtask

    // Receive one packet and judge every beat
    task automatic expect_pkt(input int pk, input int len, input logic zl, input logic ff,
        input logic [3:0] fm, input logic [3:0] lm);
        int tot;
        int nb;
        int d;
        logic [255:0] pay;
        logic [7:0] kp;
        logic [84:0] sb;
        tot = 4 + len;
        nb = (tot + 1) / 2;
        for (int b = 0; b < nb; b++)
        begin
            @(negedge ref_clk_i);
            while (!(request_out_valid === 1'b1 && request_out_accept === 1'b1))
            begin
                if (b > 0)
                    chk("valid inside packet", 352'(request_out_valid), 352'h1);
                @(negedge ref_clk_i);
            end
            pay = '0;
            kp = '0;
            sb = '0;
            sb[3:0] = ff ? 4'hf : fm;
            sb[7:4] = ff ? 4'hf : lm;
            sb[40] = (b == 0);
            sb[84:41] = 44'h0ab_cd00_0000 + 44'(pk);
            for (int l = 0; l < 2; l++)
            begin
                d = 2 * b + l;
                kp[l] = (d < tot);
                pay[32 * l +: 32] = dw(pk, d, tot);
                // Descriptor and zero-length dwords carry no byte enables
                if (d >= 4 && d < tot && !zl)
                    sb[8 + 4 * l +: 4] = ff ? 4'hf : (d == 4) ? fm : (d == tot - 1) ? lm : 4'hf;
            end
            chk("payload", 352'(request_out_payload), 352'(pay));
            chk("dword keep", 352'(request_out_dword_keep), 352'(kp));
            chk("sideband", 352'(request_out_sideband), 352'(sb));
            chk("last beat", 352'(request_out_last_beat), 352'(b == nb - 1));
        end
    endtask

    // Reset keeps the stream quiet
    task automatic t_reset();
        repeat (4) @(posedge ref_clk_i);
        chk("valid in reset", 352'(request_out_valid), 352'h0);
        chk("last in reset", 352'(request_out_last_beat), 352'h0);
        chk("ready in reset", 352'(rx_ready_o), 352'h0);
        nrst_i <= 1'b1;
        $display("test reset done");
    endtask

    // One packet, sink switched to accepting every cycle before the first beat is presented
    task automatic t_stream();
        send_pkt(1, 2, 1'b0, 1'b0, 4'h3, 4'hc);
        sink_mode <= 2'h1;
        expect_pkt(1, 2, 1'b0, 1'b0, 4'h3, 4'hc);
        $display("test stream done");
    endtask

    // Three packets back to back, sink pausing every other cycle
    task automatic t_paced();
        sink_mode <= 2'h0;
        send_pkt(2, 7, 1'b0, 1'b0, 4'he, 4'h7);
        send_pkt(3, 1, 1'b0, 1'b1, 4'h1, 4'h2);
        send_pkt(4, 1, 1'b1, 1'b0, 4'h0, 4'h0);
        sink_mode <= 2'h2;
        expect_pkt(2, 7, 1'b0, 1'b0, 4'he, 4'h7);
        expect_pkt(3, 1, 1'b0, 1'b1, 4'h1, 4'h2);
        expect_pkt(4, 1, 1'b1, 1'b0, 4'h0, 4'h0);
        repeat (4) @(negedge ref_clk_i);
        chk("valid when idle", 352'(request_out_valid), 352'h0);
        chk("beats delivered", 352'(sink_beats), 352'd15);
        $display("test paced done");
    endtask

    // Main sequence
    initial
    begin
        t_reset();
        t_stream();
        t_paced();
        close_out();
    end
endmodule // crso_top_test
`default_nettype wire
